// ===== cbs_params.svh
`ifndef CBS_PARAMS_SVH
`define CBS_PARAMS_SVH

// Register indices
`define CBS_IDX_OE 8'h00
`define CBS_IDX_MODE_AMP 8'h01
`define CBS_IDX_SLEW 8'h02
`define CBS_IDX_FREQ 8'h03
`define CBS_IDX_RSVD 8'h04
`define CBS_IDX_REV_MAKER 8'h05
`define CBS_IDX_PART 8'h06
`define CBS_IDX_BCOUNT 8'h07

// Field positions
`define CBS_B1_SWSEL 5
`define CBS_B3_FREQ_EN 5

// Reset values
`define CBS_OE_RST 6'h3f
`define CBS_AMP_RST 2'h2
`define CBS_SLEW_RST 6'h3f
`define CBS_SLEW_FB_RST 1'h1
`define CBS_BCOUNT_RST 5'h08
`define CBS_RSVD_READ 8'hff

// Bus addresses per strap level
`define CBS_STRAP_LOW 2'h0
`define CBS_STRAP_MID 2'h1
`define CBS_STRAP_HIGH 2'h2
`define CBS_ADDR_LOW 7'h6b
`define CBS_ADDR_MID 7'h6c
`define CBS_ADDR_HIGH 7'h6d

// Bit phases within a byte on the serial bus
`define CBS_BIT_LAST 4'h8
`define CBS_BIT_ACK 4'h9

`endif

// ===== cbs_pkg.sv
package cbs_pkg;
  typedef enum logic [1:0] {
    CBS_IDLE = 2'b00,
    CBS_RX = 2'b01,
    CBS_TX = 2'b10,
    CBS_WAIT = 2'b11
  } cbs_state_t;

  typedef enum logic [1:0] {
    CBS_K_ADDR = 2'b00,
    CBS_K_INDEX = 2'b01,
    CBS_K_COUNT = 2'b10,
    CBS_K_DATA = 2'b11
  } cbs_kind_t;
endpackage

// ===== cbs_regs.sv
// How it works
// - A cleared output enable bit forces its output off whatever the pin says.
// - Byte 1 bits 7:6 read back the mode, its default caught at startup.
// - Byte 1 bit 5 picks the mode source: latched bits or software bits.
// - Software mode bits reset to 0 and only act when bit 5 is set.
// - Byte 1 bits 1:0 are the amplitude code, default 10.
// - Byte 2 holds six slew selects, default fast; bits 5 and 1 reserved.
// - Byte 3 bit 5 enables software frequency choice, reset 0.
// - Frequency bits 4:3 reset to 0 and act only when enabled.
// - Byte 3 bit 0 is feedback slew, default fast; bits 2:1 read one.
// - Index 4 always reads all ones.
// - Byte 5 reads fixed revision and maker codes.
// - Byte 6 reads fixed part class and part number codes.
// - Byte 7 bits 4:0 set the count byte a block read reports, default 8.
// - Block read: index written, restart with read, count then data returned.
// - Byte 0 holds six output enables, each default enabled.
module cbs_regs
  import cbs_pkg::*;
#(
  parameter logic [3:0] REVISION_CODE = 4'h3,  // Arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'h9,  // Arbitrary value
  parameter logic [1:0] PART_CLASS_CODE = 2'h2,  // Arbitrary value
  parameter logic [5:0] PART_NUMBER_CODE = 6'h15  // Arbitrary value
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic [1:0] BUS_ADDRESS_STRAP,
  input wire logic POWER_GOOD_POWERDOWN_N,
  input wire logic [1:0] LOOP_MODE_PINS,
  input wire logic [1:0] FREQUENCY_PINS,
  input wire logic [5:0] OUTPUT_ENABLE_N,
  output logic [5:0] DIFFERENTIAL_CLOCK_OUT_ON,
  output logic [1:0] LOOP_MODE,
  output logic [1:0] AMPLITUDE,
  output logic [5:0] EDGE_RATE_SELECT,
  output logic EDGE_RATE_SELECT_FEEDBACK,
  output logic [1:0] FREQUENCY_CHOICE,
  output logic [6:0] BUS_ADDRESS
);
  `include "cbs_params.svh"
  localparam int SW = 15;
  // Output order 5..0 sits at byte bits 7,6,4,3,2,0
  function automatic logic [7:0] pack_outputs(input logic [5:0] v);
    pack_outputs = {v[5], v[4], 1'b0, v[3], v[2], v[1], 1'b0, v[0]};
  endfunction
  function automatic logic [5:0] unpack_outputs(input logic [7:0] d);
    unpack_outputs = {d[7], d[6], d[4], d[3], d[2], d[0]};
  endfunction
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic scl_prev_reg, sda_prev_reg, pg_prev_reg;
  cbs_state_t state_reg, state_next;
  cbs_kind_t kind_reg, kind_next;
  logic [3:0] bitcnt_reg, bitcnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] index_reg, index_next;
  logic rw_reg, rw_next;
  logic drive_reg, drive_next;
  logic strapped_reg, strapped_next;
  logic [6:0] addr_reg, addr_next;
  logic [1:0] mode_latch_reg, mode_latch_next;
  logic [5:0] oe_reg, oe_next;
  logic mode_sel_reg, mode_sel_next;
  logic [1:0] mode_soft_reg, mode_soft_next;
  logic [1:0] amp_reg, amp_next;
  logic [5:0] slew_reg, slew_next;
  logic freq_en_reg, freq_en_next;
  logic [1:0] freq_soft_reg, freq_soft_next;
  logic slew_fb_reg, slew_fb_next;
  logic [4:0] bcount_reg, bcount_next;
  logic [5:0] out_on_reg, out_on_next;
  logic [1:0] mode_out_reg, mode_out_next;
  logic [1:0] freq_out_reg, freq_out_next;
  logic scl_s, sda_s, pg_s, start_ev, stop_ev, rise_ev, fall_ev;
  logic [1:0] strap_s, mode_pin_s, freq_pin_s, mode_applied;
  logic [5:0] oe_n_s;
  assign {scl_s, sda_s, pg_s, strap_s, mode_pin_s, freq_pin_s, oe_n_s} = sync2_reg;
  assign start_ev = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_ev = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  assign rise_ev = scl_s & ~scl_prev_reg;
  assign fall_ev = ~scl_s & scl_prev_reg;
  assign mode_applied = mode_sel_reg ? mode_soft_reg : mode_latch_reg;
  function automatic logic [7:0] read_byte(input logic [7:0] idx);
    case (idx)
      `CBS_IDX_OE: read_byte = pack_outputs(oe_reg);
      `CBS_IDX_MODE_AMP: read_byte = {mode_applied, mode_sel_reg, mode_soft_reg, 1'b1,
        amp_reg};
      `CBS_IDX_SLEW: read_byte = pack_outputs(slew_reg);
      `CBS_IDX_FREQ: read_byte = {2'b00, freq_en_reg, freq_soft_reg, 2'b11,
        slew_fb_reg};
      `CBS_IDX_RSVD: read_byte = `CBS_RSVD_READ;
      `CBS_IDX_REV_MAKER: read_byte = {REVISION_CODE, MAKER_CODE};
      `CBS_IDX_PART: read_byte = {PART_CLASS_CODE, PART_NUMBER_CODE};
      `CBS_IDX_BCOUNT: read_byte = {3'b000, bcount_reg};
      default: read_byte = 8'h00;
    endcase
  endfunction
  always_comb
  begin
    state_next = state_reg;
    kind_next = kind_reg;
    bitcnt_next = bitcnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    index_next = index_reg;
    rw_next = rw_reg;
    drive_next = drive_reg;
    strapped_next = strapped_reg;
    addr_next = addr_reg;
    mode_latch_next = mode_latch_reg;
    oe_next = oe_reg;
    mode_sel_next = mode_sel_reg;
    mode_soft_next = mode_soft_reg;
    amp_next = amp_reg;
    slew_next = slew_reg;
    freq_en_next = freq_en_reg;
    freq_soft_next = freq_soft_reg;
    slew_fb_next = slew_fb_reg;
    bcount_next = bcount_reg;
    // Strap and mode pins caught once, on the first power good only
    if (pg_s && !pg_prev_reg && !strapped_reg)
    begin
      strapped_next = 1'b1;
      mode_latch_next = mode_pin_s;
      case (strap_s)
        `CBS_STRAP_LOW: addr_next = `CBS_ADDR_LOW;
        `CBS_STRAP_MID: addr_next = `CBS_ADDR_MID;
        `CBS_STRAP_HIGH: addr_next = `CBS_ADDR_HIGH;
        default: addr_next = `CBS_ADDR_HIGH;
      endcase
    end
    if (start_ev)
    begin
      // Repeated start keeps the index so a read follows the written index
      state_next = CBS_RX;
      kind_next = CBS_K_ADDR;
      bitcnt_next = 4'h0;
      drive_next = 1'b0;
    end
    else if (stop_ev)
    begin
      state_next = CBS_IDLE;
      drive_next = 1'b0;
    end
    else if (rise_ev)
    begin
      if (bitcnt_reg != `CBS_BIT_ACK)
        bitcnt_next = bitcnt_reg + 4'h1;
      if (state_reg == CBS_RX && bitcnt_reg < `CBS_BIT_LAST)
        shift_next = {shift_reg[6:0], sda_s};
      // Host not-acknowledge ends the read
      if (state_reg == CBS_TX && bitcnt_reg == `CBS_BIT_LAST && sda_s)
        state_next = CBS_WAIT;
    end
    else if (fall_ev)
    begin
      case (state_reg)
        CBS_RX:
        begin
          if (bitcnt_reg == `CBS_BIT_LAST)
          begin
            drive_next = 1'b1;
            case (kind_reg)
              CBS_K_ADDR:
              begin
                rw_next = shift_reg[0];
                if (shift_reg[7:1] != addr_reg)
                begin
                  drive_next = 1'b0;
                  state_next = CBS_WAIT;
                end
              end
              CBS_K_INDEX: index_next = shift_reg;
              CBS_K_COUNT: index_next = index_reg;
              default:
              begin
                index_next = index_reg + 8'h01;
                case (index_reg)
                  `CBS_IDX_OE: oe_next = unpack_outputs(shift_reg);
                  `CBS_IDX_MODE_AMP:
                  begin
                    mode_sel_next = shift_reg[`CBS_B1_SWSEL];
                    mode_soft_next = shift_reg[4:3];
                    amp_next = shift_reg[1:0];
                  end
                  `CBS_IDX_SLEW: slew_next = unpack_outputs(shift_reg);
                  `CBS_IDX_FREQ:
                  begin
                    freq_en_next = shift_reg[`CBS_B3_FREQ_EN];
                    freq_soft_next = shift_reg[4:3];
                    slew_fb_next = shift_reg[0];
                  end
                  `CBS_IDX_BCOUNT: bcount_next = shift_reg[4:0];
                  default: bcount_next = bcount_reg;
                endcase
              end
            endcase
          end
          else if (bitcnt_reg == `CBS_BIT_ACK)
          begin
            drive_next = 1'b0;
            bitcnt_next = 4'h0;
            case (kind_reg)
              CBS_K_ADDR:
              begin
                if (rw_reg)
                begin
                  // Read answers with the count byte first
                  state_next = CBS_TX;
                  kind_next = CBS_K_COUNT;
                  tx_next = {3'b000, bcount_reg};
                  drive_next = ~tx_next[7];
                end
                else
                  kind_next = CBS_K_INDEX;
              end
              CBS_K_INDEX: kind_next = CBS_K_COUNT;
              default: kind_next = CBS_K_DATA;
            endcase
          end
        end
        CBS_TX:
        begin
          if (bitcnt_reg >= 4'h1 && bitcnt_reg <= 4'h7)
          begin
            tx_next = {tx_reg[6:0], 1'b0};
            drive_next = ~tx_reg[6];
          end
          else if (bitcnt_reg == `CBS_BIT_LAST)
            drive_next = 1'b0;
          else if (bitcnt_reg == `CBS_BIT_ACK)
          begin
            // Data keeps flowing until the host declines a byte
            bitcnt_next = 4'h0;
            kind_next = CBS_K_DATA;
            tx_next = read_byte(index_reg);
            index_next = index_reg + 8'h01;
            drive_next = ~tx_next[7];
          end
        end
        default: drive_next = 1'b0;
      endcase
    end
  end
  always_comb
  begin
    out_on_next = oe_reg & ~oe_n_s;
    mode_out_next = mode_applied;
    freq_out_next = freq_en_reg ? freq_soft_reg : freq_pin_s;
  end
  always_ff @(posedge CLK)
  begin
    // Pins are asynchronous to CLK
    sync1_reg <= {SCL_IN, SDA_IN, POWER_GOOD_POWERDOWN_N, BUS_ADDRESS_STRAP,
      LOOP_MODE_PINS, FREQUENCY_PINS, OUTPUT_ENABLE_N};
    if (RST)
    begin
      sync2_reg <= {3'b110, 6'h00, 6'h3f};  // Enable pins read as off until synced
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      pg_prev_reg <= 1'b0;
      state_reg <= CBS_IDLE;
      kind_reg <= CBS_K_ADDR;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      index_reg <= 8'h00;
      rw_reg <= 1'b0;
      drive_reg <= 1'b0;
      strapped_reg <= 1'b0;
      addr_reg <= `CBS_ADDR_LOW;
      mode_latch_reg <= 2'h0;
      oe_reg <= `CBS_OE_RST;
      mode_sel_reg <= 1'b0;
      mode_soft_reg <= 2'h0;
      amp_reg <= `CBS_AMP_RST;
      slew_reg <= `CBS_SLEW_RST;
      freq_en_reg <= 1'b0;
      freq_soft_reg <= 2'h0;
      slew_fb_reg <= `CBS_SLEW_FB_RST;
      bcount_reg <= `CBS_BCOUNT_RST;
      out_on_reg <= 6'h00;
      mode_out_reg <= 2'h0;
      freq_out_reg <= 2'h0;
    end
    else
    begin
      sync2_reg <= sync1_reg;
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
      pg_prev_reg <= pg_s;
      state_reg <= state_next;
      kind_reg <= kind_next;
      bitcnt_reg <= bitcnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      index_reg <= index_next;
      rw_reg <= rw_next;
      drive_reg <= drive_next;
      strapped_reg <= strapped_next;
      addr_reg <= addr_next;
      mode_latch_reg <= mode_latch_next;
      oe_reg <= oe_next;
      mode_sel_reg <= mode_sel_next;
      mode_soft_reg <= mode_soft_next;
      amp_reg <= amp_next;
      slew_reg <= slew_next;
      freq_en_reg <= freq_en_next;
      freq_soft_reg <= freq_soft_next;
      slew_fb_reg <= slew_fb_next;
      bcount_reg <= bcount_next;
      out_on_reg <= out_on_next;
      mode_out_reg <= mode_out_next;
      freq_out_reg <= freq_out_next;
    end
  end
  // Open drain: only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = drive_reg;
  assign DIFFERENTIAL_CLOCK_OUT_ON = out_on_reg;
  assign LOOP_MODE = mode_out_reg;
  assign AMPLITUDE = amp_reg;
  assign EDGE_RATE_SELECT = slew_reg;
  assign EDGE_RATE_SELECT_FEEDBACK = slew_fb_reg;
  assign FREQUENCY_CHOICE = freq_out_reg;
  assign BUS_ADDRESS = addr_reg;
endmodule

// ===== cbs_regs_chk.sv
module cbs_regs_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCL_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic [1:0] BUS_ADDRESS_STRAP,
  input wire logic POWER_GOOD_POWERDOWN_N,
  input wire logic [5:0] OUTPUT_ENABLE_N,
  input wire logic [5:0] DIFFERENTIAL_CLOCK_OUT_ON,
  input wire logic [1:0] LOOP_MODE,
  input wire logic [1:0] AMPLITUDE,
  input wire logic [5:0] EDGE_RATE_SELECT,
  input wire logic EDGE_RATE_SELECT_FEEDBACK,
  input wire logic [1:0] FREQUENCY_CHOICE,
  input wire logic [6:0] BUS_ADDRESS
);
  logic [1:0] lvl;
  logic [6:0] exp_addr;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Strap code 11 behaves as high
  assign lvl = (BUS_ADDRESS_STRAP == 2'h3) ? 2'h2 : BUS_ADDRESS_STRAP;
  assign exp_addr = 7'h6b + {5'h00, lvl};
  // Data moves only once the clock has been low for two cycles
  property p_sda; $changed(SDA_OE) |-> SDA_OUT == 1'b0 && !$past(SCL_IN, 1)
    && !$past(SCL_IN, 2); endproperty
  a_sda: assert property (p_sda) else $error("data moved too soon after clock fall");
  property p_oe_low; $changed(SDA_OE) |-> !SCL_IN; endproperty
  a_oe_low: assert property (p_oe_low) else $error("data moved with clock high");
  property p_oe_hold; $rose(SDA_OE) |-> SDA_OE [*8]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("acknowledge too short");
  // Pin latency may be two to four cycles
  property p_pin; (DIFFERENTIAL_CLOCK_OUT_ON & $past(OUTPUT_ENABLE_N, 2)
    & $past(OUTPUT_ENABLE_N, 3) & $past(OUTPUT_ENABLE_N, 4)) == 6'h00; endproperty
  a_pin: assert property (p_pin) else $error("output on while pin disables it");
  property p_pick; $rose(POWER_GOOD_POWERDOWN_N) |-> ##[1:8] BUS_ADDRESS == exp_addr; endproperty
  a_pick: assert property (p_pick) else $error("address not taken from strap");
  property p_legal; BUS_ADDRESS inside {7'h6b, 7'h6c, 7'h6d}; endproperty
  a_legal: assert property (p_legal) else $error("address out of set");
  property p_ctl;
    $changed({AMPLITUDE, EDGE_RATE_SELECT, EDGE_RATE_SELECT_FEEDBACK}) |-> !SCL_IN;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control moved outside a write");
  property p_rst; $fell(RST) |-> AMPLITUDE == 2'h2 && EDGE_RATE_SELECT == 6'h3f
    && EDGE_RATE_SELECT_FEEDBACK; endproperty
  a_rst: assert property (p_rst) else $error("wrong control defaults");
  c_ack: cover property ($rose(SDA_OE));
  c_soft: cover property (LOOP_MODE == 2'h3);
  c_freq: cover property (FREQUENCY_CHOICE == 2'h3);
endmodule

bind cbs_regs cbs_regs_chk chk_u (.CLK(CLK), .RST(RST), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .BUS_ADDRESS_STRAP(BUS_ADDRESS_STRAP),
  .POWER_GOOD_POWERDOWN_N(POWER_GOOD_POWERDOWN_N), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
  .DIFFERENTIAL_CLOCK_OUT_ON(DIFFERENTIAL_CLOCK_OUT_ON), .LOOP_MODE(LOOP_MODE),
  .AMPLITUDE(AMPLITUDE), .EDGE_RATE_SELECT(EDGE_RATE_SELECT),
  .EDGE_RATE_SELECT_FEEDBACK(EDGE_RATE_SELECT_FEEDBACK),
  .FREQUENCY_CHOICE(FREQUENCY_CHOICE), .BUS_ADDRESS(BUS_ADDRESS));

// ===== cbs_host.sv
module cbs_host (
  input wire logic CLK,
  input wire logic sda_w,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  int half = 5;
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // Start, repeated start or stop; clock rests high between frames
  task automatic cond(input logic a, input logic b);
    tick(half);
    sda = a;
    tick(half);
    scl = 1'b1;
    tick(2 * half);
    sda = b;
    tick(2 * half);
    scl = b;
  endtask
  // Data moves only well inside the low half
  task automatic xbit(input logic b, output logic v);
    tick(half);
    sda = b;
    tick(half);
    scl = 1'b1;
    tick(half);
    v = sda_w;
    tick(half);
    scl = 1'b0;
  endtask
  // A byte MSB first, then the acknowledge slot
  task automatic xbyte(input logic [8:0] d, output logic [8:0] v);
    for (int i = 8; i >= 0; i--)
      xbit(d[i], v[i]);
  endtask
endmodule

// ===== cbs_regs_tb.sv
module cbs_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pg = 1'b0;
  logic [1:0] strap = 2'h0;
  logic [5:0] oe_n = 6'h00;
  logic [1:0] mode_pins = 2'h2;
  logic [1:0] freq_pins = 2'h1;
  logic scl;
  logic sda_h;
  logic sda_oe;
  logic [5:0] clk_on;
  logic [5:0] slew;
  logic [1:0] mode;
  logic [1:0] amp;
  logic [1:0] fsel;
  logic fb;
  logic [6:0] addr;
  logic [6:0] dev = 7'h6b;
  logic [7:0] bc = 8'h08;
  logic [8:0] r;
  logic [7:0] q[$];
  int fails = 0;
  int tests_run = 0;
  // Index, value after reset, value written, value then read
  logic [7:0] rows [9][4] = '{'{8'h01, 8'h86, 8'hff, 8'hff}, '{8'h02, 8'hdd, 8'h22, 8'h00},
    '{8'h03, 8'h07, 8'hff, 8'h3f}, '{8'h04, 8'hff, 8'h00, 8'hff}, '{8'h05, 8'h5a, 8'h00, 8'h5a},
    '{8'h06, 8'hea, 8'h00, 8'hea}, '{8'h08, 8'h00, 8'hff, 8'h00}, '{8'h00, 8'hdd, 8'h22, 8'h00},
    '{8'h07, 8'h08, 8'hff, 8'h1f}};
  wire sda_w = sda_h & ~sda_oe;
  always #2 clk = ~clk;
  // Identity codes are arbitrary values
  cbs_regs #(.REVISION_CODE(4'h5), .MAKER_CODE(4'ha), .PART_CLASS_CODE(2'h3),
    .PART_NUMBER_CODE(6'h2a)) dut_u (.CLK(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda_w),
    .SDA_OUT(), .SDA_OE(sda_oe), .BUS_ADDRESS_STRAP(strap), .POWER_GOOD_POWERDOWN_N(pg),
    .LOOP_MODE_PINS(mode_pins), .FREQUENCY_PINS(freq_pins), .OUTPUT_ENABLE_N(oe_n),
    .DIFFERENTIAL_CLOCK_OUT_ON(clk_on), .LOOP_MODE(mode), .AMPLITUDE(amp),
    .EDGE_RATE_SELECT(slew), .EDGE_RATE_SELECT_FEEDBACK(fb), .FREQUENCY_CHOICE(fsel),
    .BUS_ADDRESS(addr));
  cbs_host host_u (.CLK(clk), .sda_w(sda_w), .scl(scl), .sda(sda_h));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] s);
    rst = 1'b1;
    pg = 1'b0;
    strap = s;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    pg = 1'b1;
    repeat (20) @(posedge clk);
    #1;
  endtask
  task automatic wb(input logic [7:0] b, input logic na);
    host_u.xbyte({b, 1'b1}, r);
    check("ack", r[0], na);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d[$],
    input logic na);
    host_u.cond(1'b1, 1'b0);
    wb({a, 1'b0}, na);
    wb(idx, na);
    wb(8'(d.size()), na);
    foreach (d[i])
      wb(d[i], na);
    host_u.cond(1'b0, 1'b1);
  endtask
  // Leaves the count byte then n data bytes in q
  task automatic rd(input logic [7:0] idx, input int n);
    host_u.cond(1'b1, 1'b0);
    wb({dev, 1'b0}, 1'b0);
    wb(idx, 1'b0);
    host_u.cond(1'b1, 1'b0);
    wb({dev, 1'b1}, 1'b0);
    q = {};
    for (int i = 0; i <= n; i++)
    begin
      host_u.xbyte({8'hff, 1'(i == n)}, r);
      q.push_back(r[8:1]);
    end
    host_u.cond(1'b0, 1'b1);
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    end_of_test();
  end
  initial
  begin
    do_reset(2'h0);
    check("address", addr, 7'h6b);
    check("mode", mode, 2'h2);
    check("outputs on", clk_on, 6'h3f);
    foreach (rows[i])
    begin
      rd(rows[i][0], 1);
      check("count", q[0], bc);
      check("reset value", q[1], rows[i][1]);
      wr(dev, rows[i][0], {rows[i][2]}, 1'b0);
      if (rows[i][0] == 8'h07)
        bc = rows[i][3];
      rd(rows[i][0], 1);
      check("count", q[0], bc);
      check("written", q[1], rows[i][3]);
    end
    check("mode", mode, 2'h3);
    check("freq", fsel, 2'h3);
    check("amp", amp, 2'h3);
    check("outputs on", clk_on, 6'h00);
    check("slew", {fb, slew}, 7'h40);
    wr(dev, 8'h01, {8'h18}, 1'b0);
    rd(8'h01, 1);
    check("mode held", mode, 2'h2);
    check("amp", amp, 2'h0);
    check("mode readback", q[1], 8'h9c);
    wr(dev, 8'h02, {8'h81, 8'h21}, 1'b0);
    rd(8'h02, 2);
    check("slew", slew, 6'h21);
    check("freq", fsel, 2'h0);
    check("block read", {q[1], q[2]}, 16'h8127);
    wr(dev, 8'h03, {8'h18}, 1'b0);
    check("freq pins", fsel, 2'h1);
    host_u.half = 9;
    wr(dev, 8'h01, {8'h01}, 1'b0);
    host_u.half = 5;
    check("amp slow host", amp, 2'h1);
    wr(7'h6c, 8'h01, {8'h02}, 1'b1);
    check("amp foreign", amp, 2'h1);
    mode_pins = 2'h1;
    for (int s = 3; s >= 1; s--)
    begin
      do_reset(2'(s));
      check("address", addr, (s == 3) ? 7'h6d : 7'h6b + 7'(s));
    end
    mode_pins = 2'h3;
    dev = 7'h6c;
    rd(8'h01, 1);
    check("mode latched", mode, 2'h1);
    check("reset again", q[1], 8'h46);
    oe_n = 6'h01;
    freq_pins = 2'h2;
    repeat (6) @(posedge clk);
    #1;
    check("pin disable", clk_on, 6'h3e);
    check("freq pins", fsel, 2'h2);
    end_of_test();
  end
endmodule
